// ---- src/iopc_device.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "iopc_map.svh"

module iopc_device
   import iopc_pkg::*;
#(
   parameter int FEAT_N = `IOPC_FEAT_N
) (
   input wire logic clk,
   input wire logic resetn,
   iopc_if.dev link,
   input wire logic locked_smpte,
   input wire logic rate_detect_hd,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [FEAT_N-1:0] feature_enable,
   output iopc_mode_t op_mode,
   output logic descramble_en,
   output logic upper_lane_zero,
   output logic hd_active,
   output logic pins_hiz,
   output logic test_port_reset,
   output logic fn_reset_n
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int SYNC_W = 6;
   logic [SYNC_W-1:0] pin_meta;
   logic [SYNC_W-1:0] pin_sync;
   logic enable_s;
   logic ts_s;
   logic rate_s;
   logic master_s;
   logic test_s;
   logic video_s;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {link.video_mode, link.test_sel, link.master_sel,
                      link.rate_sel, link.ts_mode, link.master_enable};
         pin_sync <= pin_meta;
      end
   end

   assign enable_s = pin_sync[0];
   assign ts_s = pin_sync[1];
   assign rate_s = pin_sync[2];
   assign master_s = pin_sync[3];
   assign test_s = pin_sync[4];
   assign video_s = pin_sync[5];

   // ----------------------------------------------------------------
   // Reset pin: asynchronous assert, synchronous release
   // ----------------------------------------------------------------
   logic arst_n;
   logic rst_meta;
   logic rst_sync;

   // Combined so that a pin reset takes effect without a clock edge
   assign arst_n = resetn & link.reset_pin_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Level copy of the pin used to steer the mode-dependent reset outputs
   logic prst_meta;
   logic prst_sync;

   // Reset as if the pin were asserted: the host holds it low out of reset,
   // and a clear copy would let the tristate flag drop for two cycles.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prst_meta <= 1'b1;
         prst_sync <= 1'b1;
      end else begin
         prst_meta <= ~link.reset_pin_n;
         prst_sync <= prst_meta;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fn_reset_n <= 1'b0;
      end else begin
         fn_reset_n <= rst_sync;
      end
   end

   // ----------------------------------------------------------------
   // Host-mode tristate and test-port reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins_hiz <= 1'b1;
         test_port_reset <= 1'b1;
      end else begin
         pins_hiz <= prst_sync & ~test_s;
         test_port_reset <= prst_sync & test_s;
      end
   end

   // ----------------------------------------------------------------
   // Video-mode pin driver
   // ----------------------------------------------------------------
   // The enable drops the moment the pin reset arrives, so the pin floats
   // even before the clocked tristate flag catches up.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         link.video_dev_oe <= 1'b0;
         link.video_dev_o <= 1'b0;
      end else begin
         link.video_dev_oe <= master_s;
         link.video_dev_o <= master_s & locked_smpte;
      end
   end

   // ----------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------
   logic video_eff;
   logic hd_eff;
   iopc_mode_t next_mode;

   // In master mode the device's own lock status stands in for the pin
   assign video_eff = master_s ? locked_smpte : video_s;
   // Rate pin low selects the high-definition rates
   assign hd_eff = master_s ? rate_detect_hd : ~rate_s;

   always_comb begin
      if (video_eff && !ts_s) begin
         next_mode = IOPC_MODE_SMPTE;
      end else if (ts_s) begin
         next_mode = IOPC_MODE_TS;
      end else begin
         next_mode = IOPC_MODE_THRU;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op_mode <= IOPC_MODE_THRU;
         descramble_en <= 1'b0;
         upper_lane_zero <= 1'b0;
         hd_active <= 1'b0;
      end else begin
         op_mode <= next_mode;
         descramble_en <= (next_mode == IOPC_MODE_SMPTE);
         upper_lane_zero <= (next_mode == IOPC_MODE_TS);
         hd_active <= hd_eff;
      end
   end

   // ----------------------------------------------------------------
   // Per-feature disable register
   // ----------------------------------------------------------------
   logic [FEAT_N-1:0] per_feature_disable_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         per_feature_disable_reg <= `IOPC_FEAT_DIS_RST;
      end else if (wr && addr == `IOPC_DEV_FEAT_DIS) begin
         per_feature_disable_reg <= wdata[FEAT_N-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Feature enables
   // ----------------------------------------------------------------
   logic [FEAT_N-1:0] next_feat;
   logic proc_ok;

   // Nothing runs outside SMPTE mode, and nothing without the master-enable pin
   assign proc_ok = enable_s & (next_mode == IOPC_MODE_SMPTE);

   always_comb begin
      next_feat = '0;
      if (proc_ok) begin
         next_feat = ~per_feature_disable_reg;
         next_feat[`IOPC_FEAT_EDH] = ~per_feature_disable_reg[`IOPC_FEAT_EDH] & ~hd_eff;
         next_feat[`IOPC_FEAT_LCRC] = ~per_feature_disable_reg[`IOPC_FEAT_LCRC] & hd_eff;
         next_feat[`IOPC_FEAT_LNUM] = ~per_feature_disable_reg[`IOPC_FEAT_LNUM] & hd_eff;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         feature_enable <= '0;
      end else begin
         feature_enable <= next_feat;
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   logic [31:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[FEAT_N-1:0] = feature_enable;
      status_word[`IOPC_ST_MODE_HI:`IOPC_ST_MODE_LO] = op_mode;
      status_word[`IOPC_ST_MASTER] = master_s;
      status_word[`IOPC_ST_TEST] = test_s;
      status_word[`IOPC_ST_HIZ] = pins_hiz;
      status_word[`IOPC_ST_HD] = hd_active;
      status_word[`IOPC_ST_FNRST] = ~fn_reset_n;
   end

   // Read data stand for one cycle only; unmapped reads return zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            `IOPC_DEV_FEAT_DIS: rdata <= {{(32-FEAT_N){1'b0}}, per_feature_disable_reg};
            `IOPC_DEV_STATUS: rdata <= status_word;
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

endmodule : iopc_device

`default_nettype wire

// ---- src/iopc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "iopc_map.svh"

module iopc_host
   import iopc_pkg::*;
#(
   parameter int RST_PULSE_CYC = (`IOPC_RST_PULSE_NS + `IOPC_CLK_PERIOD_NS - 1) / `IOPC_CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic resetn,
   iopc_if.host link,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);

   // ----------------------------------------------------------------
   // Control register and pin drivers
   // ----------------------------------------------------------------
   logic [6:0] ctrl;
   logic ctrl_wr;
   logic rate_change;
   logic configured;

   assign ctrl_wr = wr && addr == `IOPC_HOST_CTRL;
   assign rate_change = ctrl_wr && (wdata[`IOPC_CTRL_RATE] != ctrl[`IOPC_CTRL_RATE]);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= `IOPC_CTRL_RST;
         configured <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl <= wdata[6:0];
         configured <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link.master_enable <= 1'b0;
         link.ts_mode <= 1'b0;
         link.rate_sel <= 1'b0;
         link.master_sel <= 1'b0;
         link.test_sel <= 1'b0;
         link.video_host_o <= 1'b0;
         link.video_host_oe <= 1'b0;
      end else begin
         link.master_enable <= ctrl[`IOPC_CTRL_EN];
         link.ts_mode <= ctrl[`IOPC_CTRL_TS];
         link.rate_sel <= ctrl[`IOPC_CTRL_RATE];
         link.master_sel <= ctrl[`IOPC_CTRL_MASTER];
         link.test_sel <= ctrl[`IOPC_CTRL_TEST];
         link.video_host_o <= ctrl[`IOPC_CTRL_VIDEO];
         // Release the pin in master mode; a return to slave without a pin reset has both driving for three cycles
         link.video_host_oe <= ~ctrl[`IOPC_CTRL_MASTER];
      end
   end

   // ----------------------------------------------------------------
   // Reset pulse sequencer
   // ----------------------------------------------------------------
   iopc_hstate_t state;
   logic [15:0] pulse_cnt;
   logic pulse_req;

   // First configuration and every rate change in slave mode need a pulse
   assign pulse_req = (ctrl_wr && wdata[`IOPC_CTRL_RESET]) ||
                      (ctrl_wr && !wdata[`IOPC_CTRL_MASTER] && (rate_change || !configured));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= IOPC_HST_PULSE;
         pulse_cnt <= '0;
      end else begin
         case (state)
            IOPC_HST_IDLE: begin
               pulse_cnt <= '0;
               if (pulse_req) begin
                  state <= IOPC_HST_PULSE;
               end
            end
            IOPC_HST_PULSE: begin
               if (pulse_cnt == 16'(RST_PULSE_CYC - 1)) begin
                  state <= IOPC_HST_IDLE;
                  pulse_cnt <= '0;
               end else begin
                  pulse_cnt <= pulse_cnt + 16'h0001;
               end
            end
            default: begin
               state <= IOPC_HST_IDLE;
               pulse_cnt <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link.reset_pin_n <= 1'b0;
      end else begin
         link.reset_pin_n <= (state == IOPC_HST_IDLE) && !pulse_req;
      end
   end

   // ----------------------------------------------------------------
   // Status readback
   // ----------------------------------------------------------------
   logic vid_meta;
   logic vid_sync;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vid_meta <= 1'b0;
         vid_sync <= 1'b0;
      end else begin
         vid_meta <= link.video_mode;
         vid_sync <= vid_meta;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            `IOPC_HOST_CTRL: rdata <= {25'h0000000, ctrl};
            `IOPC_HOST_STATUS: rdata <= {29'h00000000, configured,
                                         state == IOPC_HST_PULSE, vid_sync};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

endmodule : iopc_host

`default_nettype wire

// ---- src/iopc_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface iopc_if;
   logic master_enable;
   logic ts_mode;
   logic rate_sel;
   logic master_sel;
   logic test_sel;
   logic reset_pin_n;
   logic video_dev_o;
   logic video_dev_oe;
   logic video_host_o;
   logic video_host_oe;
   logic video_mode;

   // Resolved pin level; the pull-up wins when nobody drives
   assign video_mode = video_dev_oe ? video_dev_o : (video_host_oe ? video_host_o : 1'b1);

   modport dev (
      input master_enable, ts_mode, rate_sel, master_sel, test_sel, reset_pin_n,
      input video_mode,
      output video_dev_o, video_dev_oe
   );

   modport host (
      output master_enable, ts_mode, rate_sel, master_sel, test_sel, reset_pin_n,
      output video_host_o, video_host_oe,
      input video_mode
   );
endinterface : iopc_if

`default_nettype wire

// ---- src/iopc_map.svh ----
`ifndef IOPC_MAP_SVH
`define IOPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define IOPC_DEV_FEAT_DIS 8'h00
`define IOPC_DEV_STATUS 8'h04
`define IOPC_HOST_CTRL 8'h00
`define IOPC_HOST_STATUS 8'h04

// ----------------------------------------------------------------
// Feature bit positions (per-feature disable and enable vectors)
// ----------------------------------------------------------------
`define IOPC_FEAT_N 6
`define IOPC_FEAT_EDH 0
`define IOPC_FEAT_ANC 1
`define IOPC_FEAT_LCRC 2
`define IOPC_FEAT_LNUM 3
`define IOPC_FEAT_TRS 4
`define IOPC_FEAT_REMAP 5
`define IOPC_FEAT_DIS_RST 6'h00

// ----------------------------------------------------------------
// Device status fields
// ----------------------------------------------------------------
`define IOPC_ST_MODE_LO 6
`define IOPC_ST_MODE_HI 7
`define IOPC_ST_MASTER 8
`define IOPC_ST_TEST 9
`define IOPC_ST_HIZ 10
`define IOPC_ST_HD 11
`define IOPC_ST_FNRST 12

// ----------------------------------------------------------------
// Host control and status fields
// ----------------------------------------------------------------
`define IOPC_CTRL_EN 0
`define IOPC_CTRL_TS 1
`define IOPC_CTRL_VIDEO 2
`define IOPC_CTRL_RATE 3
`define IOPC_CTRL_MASTER 4
`define IOPC_CTRL_TEST 5
`define IOPC_CTRL_RESET 6
`define IOPC_CTRL_RST 7'h00
`define IOPC_HST_VIDEO 0
`define IOPC_HST_BUSY 1
`define IOPC_HST_CONF 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOPC_CLK_PERIOD_NS 5
`define IOPC_RST_PULSE_NS 100

`endif

// ---- src/iopc_pkg.sv ----
package iopc_pkg;

   typedef enum logic [1:0] {
      IOPC_MODE_SMPTE = 2'b00,
      IOPC_MODE_TS = 2'b01,
      IOPC_MODE_THRU = 2'b10
   } iopc_mode_t;

   typedef enum logic {
      IOPC_HST_IDLE = 1'b0,
      IOPC_HST_PULSE = 1'b1
   } iopc_hstate_t;

endpackage : iopc_pkg

// ---- tb/iopc_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none

module iopc_monitor
   import iopc_pkg::*;
#(
   parameter int FEAT_N = 6
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic master_enable,
   input wire logic ts_mode,
   input wire logic master_sel,
   input wire logic test_sel,
   input wire logic reset_pin_n,
   input wire logic video_dev_o,
   input wire logic video_dev_oe,
   input wire logic video_host_oe,
   input wire logic video_mode,
   input wire logic locked_smpte,
   input wire logic [FEAT_N-1:0] feature_enable,
   input wire iopc_mode_t op_mode,
   input wire logic pins_hiz,
   input wire logic test_port_reset,
   input wire logic fn_reset_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // Pin reset sequencing
   // ----------------------------------------------------------------
   sequence s_pin_release;
      $rose(reset_pin_n);
   endsequence
   sequence s_fn_held;
      !fn_reset_n [*2];
   endsequence
   property p_fn_release;
      s_pin_release |-> s_fn_held ##[1:3] fn_reset_n;
   endproperty
   a_fn_release: assert property (p_fn_release) else $error("late functional release");
   property p_pin_clears;
      !reset_pin_n |-> !fn_reset_n && feature_enable == {FEAT_N{1'b0}} && !video_dev_oe;
   endproperty
   a_pin_clears: assert property (p_pin_clears) else $error("pin reset not clearing");
   property p_hiz;
      (!reset_pin_n && !test_sel) [*4] |-> pins_hiz;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pins not tristated");
   property p_test_hold;
      (!reset_pin_n && test_sel) [*4] |-> test_port_reset;
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("test sequence not held");
   property p_test_run;
      (reset_pin_n && test_sel) [*4] |-> !test_port_reset;
   endproperty
   a_test_run: assert property (p_test_run) else $error("test sequence still held");

   // ----------------------------------------------------------------
   // Features and modes
   // ----------------------------------------------------------------
   property p_feat_off;
      !master_enable [*4] |-> feature_enable == {FEAT_N{1'b0}};
   endproperty
   a_feat_off: assert property (p_feat_off) else $error("features on while disabled");
   property p_smpte;
      (!master_sel && video_mode && !ts_mode && reset_pin_n) [*7] |-> op_mode == IOPC_MODE_SMPTE;
   endproperty
   a_smpte: assert property (p_smpte) else $error("slave SMPTE mode missing");
   property p_dev_drive;
      (master_sel && reset_pin_n) [*6] |-> video_dev_oe;
   endproperty
   a_dev_drive: assert property (p_dev_drive) else $error("device not driving video pin");
   property p_dev_quiet;
      !master_sel [*4] |-> !video_dev_oe;
   endproperty
   a_dev_quiet: assert property (p_dev_quiet) else $error("device drives in slave");
   property p_host_quiet;
      master_sel [*2] |-> !video_host_oe;
   endproperty
   a_host_quiet: assert property (p_host_quiet) else $error("host drives in master");
   property p_lock_level;
      $stable(locked_smpte) [*4] ##0 video_dev_oe |-> video_dev_o == locked_smpte;
   endproperty
   a_lock_level: assert property (p_lock_level) else $error("video pin not lock");
endmodule : iopc_monitor

`default_nettype wire

// ---- tb/iopc_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "iopc_map.svh"

module iopc_test
   import iopc_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic locked_smpte = 1'b0;
   logic rate_detect_hd = 1'b1;
   logic [7:0] h_addr = 8'h00;
   logic [7:0] d_addr = 8'h00;
   logic [31:0] h_wdata = 32'h0;
   logic [31:0] d_wdata = 32'h0;
   logic h_wr = 1'b0;
   logic h_rd = 1'b0;
   logic d_wr = 1'b0;
   logic d_rd = 1'b0;
   logic [31:0] h_rdata;
   logic [31:0] d_rdata;
   logic [5:0] feature_enable;
   iopc_mode_t op_mode;
   logic descramble_en;
   logic upper_lane_zero;
   logic hd_active;
   logic pins_hiz;
   logic test_port_reset;
   logic fn_reset_n;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [31:0] ctl [2] = '{32'h0B, 32'h09};
   iopc_mode_t md [2] = '{IOPC_MODE_TS, IOPC_MODE_THRU};

   always #2.5 clk = ~clk;

   iopc_if link ();
   iopc_device #(.FEAT_N(6)) iopc_device_i (.clk(clk), .resetn(resetn), .link(link.dev),
      .locked_smpte(locked_smpte), .rate_detect_hd(rate_detect_hd), .addr(d_addr),
      .wdata(d_wdata), .wr(d_wr), .rd(d_rd), .rdata(d_rdata), .feature_enable(feature_enable),
      .op_mode(op_mode), .descramble_en(descramble_en), .upper_lane_zero(upper_lane_zero),
      .hd_active(hd_active), .pins_hiz(pins_hiz), .test_port_reset(test_port_reset),
      .fn_reset_n(fn_reset_n));
   // Short pulse keeps the run brief; every wait below assumes 8
   iopc_host #(.RST_PULSE_CYC(8)) iopc_host_i (.clk(clk), .resetn(resetn), .link(link.host),
      .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd), .rdata(h_rdata));
   iopc_monitor #(.FEAT_N(6)) iopc_monitor_i (.clk(clk), .resetn(resetn),
      .master_enable(link.master_enable), .ts_mode(link.ts_mode), .master_sel(link.master_sel),
      .test_sel(link.test_sel), .reset_pin_n(link.reset_pin_n), .video_dev_o(link.video_dev_o),
      .video_dev_oe(link.video_dev_oe), .video_host_oe(link.video_host_oe),
      .video_mode(link.video_mode), .locked_smpte(locked_smpte), .feature_enable(feature_enable),
      .op_mode(op_mode), .pins_hiz(pins_hiz), .test_port_reset(test_port_reset),
      .fn_reset_n(fn_reset_n));

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input bit dev, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      if (dev) begin
         d_addr <= a;
         d_wdata <= d;
         d_wr <= 1'b1;
      end else begin
         h_addr <= a;
         h_wdata <= d;
         h_wr <= 1'b1;
      end
      @(posedge clk);
      d_wr <= 1'b0;
      h_wr <= 1'b0;
   endtask : wr

   task automatic rd(input bit dev, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      if (dev) begin
         d_addr <= a;
         d_rd <= 1'b1;
      end else begin
         h_addr <= a;
         h_rd <= 1'b1;
      end
      @(posedge clk);
      d_rd <= 1'b0;
      h_rd <= 1'b0;
      #1;
      chk(dev ? d_rdata : h_rdata, exp);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // Hang guard, well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      idle(20);
      wr(0, `IOPC_HOST_CTRL, 32'h05);
      idle(20);
      chk(op_mode, IOPC_MODE_SMPTE);
      chk(feature_enable, 6'h3E);
      chk(descramble_en, 1'b1);
      wr(1, `IOPC_DEV_FEAT_DIS, 32'h10);
      idle(4);
      chk(feature_enable, 6'h2E);
      rd(1, `IOPC_DEV_FEAT_DIS, 32'h10);
      rd(1, 8'h08, 32'h0);
      rd(1, `IOPC_DEV_STATUS, 32'h82E);
      wr(0, `IOPC_HOST_CTRL, 32'h04);
      idle(6);
      chk(feature_enable, 6'h00);
      wr(0, `IOPC_HOST_CTRL, 32'h05);
      idle(6);
      chk(feature_enable, 6'h2E);
      $display("test features done");
      wr(0, `IOPC_HOST_CTRL, 32'h0D);
      idle(1);
      chk(link.reset_pin_n, 1'b0);
      idle(20);
      chk(feature_enable, 6'h33);
      chk(hd_active, 1'b0);
      rd(1, `IOPC_DEV_FEAT_DIS, 32'h0);
      $display("test rate done");
      for (int i = 0; i < 2; i++) begin
         wr(0, `IOPC_HOST_CTRL, ctl[i]);
         idle(8);
         chk(op_mode, md[i]);
         chk(upper_lane_zero, i == 0);
         chk(feature_enable, 6'h00);
         chk(descramble_en, 1'b0);
      end
      $display("test modes done");
      wr(0, `IOPC_HOST_CTRL, 32'h11);
      idle(8);
      chk(link.video_dev_oe, 1'b1);
      chk(link.video_mode, 1'b0);
      rd(0, `IOPC_HOST_CTRL, 32'h11);
      @(posedge clk);
      locked_smpte <= 1'b1;
      idle(6);
      chk(link.video_mode, 1'b1);
      chk(feature_enable, 6'h3E);
      rd(1, `IOPC_DEV_STATUS, 32'h93E);
      $display("test master done");
      wr(0, `IOPC_HOST_CTRL, 32'h51);
      wr(1, `IOPC_DEV_FEAT_DIS, 32'h01);
      idle(3);
      chk(pins_hiz, 1'b1);
      chk(fn_reset_n, 1'b0);
      chk(feature_enable, 6'h00);
      chk(link.video_mode, 1'b1);
      idle(20);
      rd(1, `IOPC_DEV_FEAT_DIS, 32'h0);
      chk(pins_hiz, 1'b0);
      chk(feature_enable, 6'h3E);
      $display("test host reset done");
      wr(0, `IOPC_HOST_CTRL, 32'h31);
      wr(0, `IOPC_HOST_CTRL, 32'h71);
      idle(5);
      chk(test_port_reset, 1'b1);
      chk(pins_hiz, 1'b0);
      chk(fn_reset_n, 1'b0);
      idle(20);
      chk(test_port_reset, 1'b0);
      chk(fn_reset_n, 1'b1);
      $display("test test reset done");
      wrap_up();
   end
endmodule : iopc_test

`default_nettype wire
